// File: rtl/clbg_top.sv
// Local bus glue: slave decode, arbiter, timeout, interrupt controller
`timescale 1ns/100ps
//
// Contract
// - Slave map: RAM window from zero, crate region at 0018 0000.
// - Slave map: control/status word 001B E6C0, request buffer 001C 0000.
// - Vector received over the bus is forwarded to the interrupt controller.
// - Source buffer at 0C040002 read only, mask at 0C040003, both 8 bit.
// - Reset clears all mask bits.
// - Timer and abort sources are edge sensitive, others level.
// - Serial port at 0C000000, byte accesses only.
// - Serial channel on level 2, serial timer on level 6.
// - Network interface at 0C010000, interrupt level 3.
// - Disk controller at 0C036000, level 5, vector 6D.
// - Disk buffer 64K at 0C035000, word access, counter loaded at 0C037000.
// - Control word bit 7 selects direct buffer mode.
// - Real-time clock at 0C020000, upper read nibble forced to zero.
// - Slave access arbitrates; data phase waits for the processor access.
// - External bus beats network interface for the local bus.
// - Master mode arbitrates only network interface and processor.
// - Unanswered processor access for 25 us raises the bus error strobe.
// - Control word bit 5 suppresses the bus error strobe.
// - External write of 2 to the control word gives a remote reset.
// - Slave decode uses address bits 2 to 24 only.
// - Slave window maps onto internal addresses from 04000000.
module clbg_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] crate_num_i,
  input wire logic ext_as_i,
  input wire logic ext_ds_i,
  input wire logic ext_wr_i,
  input wire logic [31:0] ext_addr_i,
  input wire logic [31:0] ext_wdata_i,
  output logic ext_asack_o,
  output logic ext_ack_o,
  output logic [31:0] ext_rdata_o,
  input wire logic cpu_req_i,
  input wire logic cpu_wr_i,
  input wire logic [1:0] cpu_size_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic [31:0] cpu_wdata_i,
  output logic cpu_ack_o,
  output logic [31:0] cpu_rdata_o,
  output logic bus_error_strobe_o,
  output logic [2:0] cpu_irq_level_o,
  output logic [7:0] cpu_irq_vector_o,
  input wire logic net_req_i,
  output logic net_gnt_o,
  output logic lb_req_o,
  output clbg_pkg::clbg_sel_t lb_sel_o,
  output logic lb_wr_o,
  output logic [31:0] lb_addr_o,
  output logic [31:0] lb_wdata_o,
  input wire logic lb_ack_i,
  input wire logic [31:0] lb_rdata_i,
  input wire logic [7:0] irq_src_i,
  input wire logic [7:0] bus_irq_vector_i,
  input wire logic [23:0] service_req_i,
  output logic slave_bus_irq_o,
  output logic direct_buffer_mode_o,
  output logic master_mode_o,
  output logic remote_reset_o
);
  import clbg_pkg::*;

  typedef enum {ST_IDLE, ST_CPU, ST_EXT, ST_NET, ST_REL} clbg_state_t;

  logic [2:0] ectl_s;
  logic [31:0] eaddr_s;
  logic [31:0] ewdata_s;
  logic [3:0] crate_s;
  logic [7:0] irq_s;
  logic [7:0] vec_s;
  logic [23:0] srb_s;

  clbg_sync #(.W(3)) u_sync_ctl (.clk_i(clk_i), .rst_i(rst_i),
    .d_i({ext_as_i, ext_ds_i, ext_wr_i}), .q_o(ectl_s));
  clbg_sync #(.W(32)) u_sync_addr (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(ext_addr_i), .q_o(eaddr_s));
  clbg_sync #(.W(32)) u_sync_wdata (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(ext_wdata_i), .q_o(ewdata_s));
  clbg_sync #(.W(4)) u_sync_crate (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(crate_num_i), .q_o(crate_s));
  clbg_sync #(.W(8)) u_sync_irq (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(irq_src_i), .q_o(irq_s));
  clbg_sync #(.W(8)) u_sync_vec (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(bus_irq_vector_i), .q_o(vec_s));
  clbg_sync #(.W(24)) u_sync_srb (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(service_req_i), .q_o(srb_s));

  clbg_state_t state_q, state_d;
  logic [2:0] strap_q, strap_d;
  logic master_q, master_d;
  logic [3:0] crate_q, crate_d;
  logic [31:0] csw_q, csw_d;
  logic [7:0] imsk_q, imsk_d;
  logic [7:0] edge_q, edge_d;
  logic [7:0] irq_prev_q, irq_prev_d;
  logic [15:0] dcnt_q, dcnt_d;
  logic [11:0] tmo_q, tmo_d;
  logic ext_asack_q, ext_asack_d;
  logic ext_ack_q, ext_ack_d;
  logic [31:0] ext_rdata_q, ext_rdata_d;
  logic cpu_ack_q, cpu_ack_d;
  logic [31:0] cpu_rdata_q, cpu_rdata_d;
  logic bus_error_strobe_q, bus_error_strobe_d;
  logic [2:0] lvl_q, lvl_d;
  logic [7:0] vec_q, vec_d;
  logic net_gnt_q, net_gnt_d;
  logic lb_req_q, lb_req_d;
  clbg_sel_t lb_sel_q, lb_sel_d;
  logic lb_wr_q, lb_wr_d;
  logic [31:0] lb_addr_q, lb_addr_d;
  logic [31:0] lb_wdata_q, lb_wdata_d;
  logic rrst_q, rrst_d;

  logic [31:0] ext_int;
  logic ext_hit;
  logic [7:0] isrc;
  logic [7:0] pend;
  logic [31:0] acc_addr;
  logic acc_wr;
  logic [31:0] acc_wdata;
  logic [1:0] acc_size;
  clbg_sel_t acc_sel;
  logic acc_ok;
  logic [31:0] rd;
  logic done;

  function automatic clbg_sel_t decode(input logic [31:0] a);
    if (a == CSW_ADDR)
      return SEL_CSW;
    if (a == SRB_ADDR)
      return SEL_SRB;
    if ((a & ~32'h001FFFFF) == SLV_BASE)
      return (a[20:0] >= SLV_CRATE_OFF) ? SEL_CRATE : SEL_RAM;
    if ((a & PAGE_MASK) == SER_BASE)
      return SEL_SER;
    if ((a & PAGE_MASK) == NET_BASE)
      return SEL_NET;
    if ((a & PAGE_MASK) == RTC_BASE)
      return SEL_RTC;
    if ((a & DPAGE_MASK) == DBUF_BASE)
      return SEL_DBUF;
    if ((a & DPAGE_MASK) == DISK_BASE)
      return SEL_DISK;
    if (a == DCNT_ADDR)
      return SEL_DCNT;
    if (a == ISRC_ADDR)
      return SEL_ISRC;
    if (a == IMSK_ADDR)
      return SEL_IMSK;
    return SEL_NONE;
  endfunction

  // Offset bits 20:2 kept, the rest rebuilt as 0,0,1 select pattern
  always_comb
  begin
    ext_int = SLV_BASE | {11'h000, eaddr_s[20:2], 2'b00};
    ext_hit = ectl_s[2] && ectl_s[1] && !master_q &&
      (eaddr_s[24:SLV_CRATE_LSB] == crate_q);
  end

  always_comb
  begin
    isrc = (irq_s & ~IRQ_EDGE_MASK) | edge_q;
    pend = isrc & imsk_q;
    acc_addr = (state_q == ST_EXT) ? ext_int : cpu_addr_i;
    acc_wr = (state_q == ST_EXT) ? ectl_s[0] : cpu_wr_i;
    acc_wdata = (state_q == ST_EXT) ? ewdata_s : cpu_wdata_i;
    acc_size = (state_q == ST_EXT) ? 2'h2 : cpu_size_i;
    acc_sel = decode(acc_addr);
    // Bad width is left unanswered so the timeout catches it
    acc_ok = !(acc_sel == SEL_NONE ||
      (acc_sel == SEL_SER && acc_size != SZ_BYTE) ||
      (acc_sel == SEL_DBUF && acc_size != SZ_WORD));
  end

  always_comb
  begin
    state_d = state_q;
    strap_d = {strap_q[1:0], 1'b1};
    master_d = master_q;
    crate_d = crate_q;
    csw_d = csw_q;
    imsk_d = imsk_q;
    irq_prev_d = irq_s;
    edge_d = edge_q | (irq_s & ~irq_prev_q & IRQ_EDGE_MASK);
    dcnt_d = dcnt_q;
    tmo_d = tmo_q;
    ext_asack_d = ext_asack_q && ectl_s[2];
    ext_ack_d = ext_ack_q && ectl_s[2];
    ext_rdata_d = ext_rdata_q;
    cpu_ack_d = 1'b0;
    cpu_rdata_d = cpu_rdata_q;
    bus_error_strobe_d = 1'b0;
    net_gnt_d = net_gnt_q;
    lb_req_d = lb_req_q;
    lb_sel_d = lb_sel_q;
    lb_wr_d = lb_wr_q;
    lb_addr_d = lb_addr_q;
    lb_wdata_d = lb_wdata_q;
    rrst_d = 1'b0;
    rd = 32'h00000000;
    done = 1'b0;
    // Strap caught once the synchroniser, cleared by reset, holds the pin
    if (strap_q == 3'b011)
    begin
      crate_d = crate_s;
      master_d = (crate_s == 4'h0);
    end
    unique case (state_q)
      ST_IDLE:
      begin
        tmo_d = '0;
        if (ext_hit && !ext_ack_q)
        begin
          state_d = ST_EXT;
          ext_asack_d = 1'b1;
        end
        else if (net_req_i)
        begin
          state_d = ST_NET;
          net_gnt_d = 1'b1;
        end
        else if (cpu_req_i && !cpu_ack_q && !bus_error_strobe_q)
          state_d = ST_CPU;
      end
      ST_CPU, ST_EXT:
      begin
        tmo_d = tmo_q + 12'h001;
        unique case (acc_sel)
          SEL_CSW: rd = csw_q;
          SEL_SRB: rd = {8'h00, srb_s};
          SEL_ISRC: rd = {24'h000000, isrc};
          SEL_IMSK: rd = {24'h000000, imsk_q};
          SEL_RTC: rd = {28'h0000000, lb_rdata_i[3:0]};
          default: rd = lb_rdata_i;
        endcase
        if (acc_ok && (acc_sel == SEL_CSW || acc_sel == SEL_SRB ||
          acc_sel == SEL_ISRC || acc_sel == SEL_IMSK || acc_sel == SEL_DCNT))
        begin
          done = 1'b1;
          if (acc_wr && acc_sel == SEL_CSW)
          begin
            csw_d = acc_wdata;
            rrst_d = (state_q == ST_EXT) &&
              (acc_wdata == CSW_REMOTE_RST);
          end
          if (acc_wr && acc_sel == SEL_IMSK)
            imsk_d = acc_wdata[7:0];
          if (acc_wr && acc_sel == SEL_DCNT)
            dcnt_d = acc_wdata[15:0];
          if (!acc_wr && acc_sel == SEL_ISRC)
            edge_d = irq_s & ~irq_prev_q & IRQ_EDGE_MASK; // new edge wins
        end
        else if (acc_ok && !lb_req_q)
        begin
          lb_req_d = 1'b1;
          lb_sel_d = acc_sel;
          lb_wr_d = acc_wr;
          lb_wdata_d = acc_wdata;
          lb_addr_d = (acc_sel == SEL_DBUF) ?
            {DBUF_BASE[31:16], dcnt_q} : acc_addr;
        end
        else if (lb_req_q && lb_ack_i)
        begin
          done = 1'b1;
          lb_req_d = 1'b0;
          if (lb_sel_q == SEL_DBUF)
            dcnt_d = dcnt_q + DCNT_STEP;
        end
        if (done)
        begin
          state_d = ST_REL;
          if (state_q == ST_EXT)
          begin
            ext_ack_d = 1'b1;
            ext_rdata_d = rd;
          end
          else
          begin
            cpu_ack_d = 1'b1;
            cpu_rdata_d = rd;
          end
        end
        else if (tmo_q == 12'(TMO_CYC - 1))
        begin
          state_d = ST_REL;
          lb_req_d = 1'b0;
          bus_error_strobe_d = (state_q == ST_CPU) && !csw_q[CSW_NOBERR_BIT];
          ext_asack_d = 1'b0;
        end
      end
      ST_NET:
      begin
        if (!net_req_i)
        begin
          net_gnt_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_REL:
        state_d = ST_IDLE;
    endcase
  end

  always_comb
  begin
    lvl_d = 3'h0;
    vec_d = 8'h00;
    for (int i = 1; i < 8; i++)
    begin
      if (pend[i])
      begin
        lvl_d = 3'(i);
        vec_d = (i == LVL_BUS) ? vec_s : VEC_BASE + 8'(i);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      strap_q <= 3'b000;
      master_q <= 1'b0;
      crate_q <= 4'h0;
      csw_q <= CSW_RESET;
      imsk_q <= IMSK_RESET;
      edge_q <= 8'h00;
      irq_prev_q <= 8'h00;
      dcnt_q <= 16'h0000;
      tmo_q <= 12'h000;
      ext_asack_q <= 1'b0;
      ext_ack_q <= 1'b0;
      ext_rdata_q <= 32'h00000000;
      cpu_ack_q <= 1'b0;
      cpu_rdata_q <= 32'h00000000;
      bus_error_strobe_q <= 1'b0;
      lvl_q <= 3'h0;
      vec_q <= 8'h00;
      net_gnt_q <= 1'b0;
      lb_req_q <= 1'b0;
      lb_sel_q <= SEL_NONE;
      lb_wr_q <= 1'b0;
      lb_addr_q <= 32'h00000000;
      lb_wdata_q <= 32'h00000000;
      rrst_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      strap_q <= strap_d;
      master_q <= master_d;
      crate_q <= crate_d;
      csw_q <= csw_d;
      imsk_q <= imsk_d;
      edge_q <= edge_d;
      irq_prev_q <= irq_prev_d;
      dcnt_q <= dcnt_d;
      tmo_q <= tmo_d;
      ext_asack_q <= ext_asack_d;
      ext_ack_q <= ext_ack_d;
      ext_rdata_q <= ext_rdata_d;
      cpu_ack_q <= cpu_ack_d;
      cpu_rdata_q <= cpu_rdata_d;
      bus_error_strobe_q <= bus_error_strobe_d;
      lvl_q <= lvl_d;
      vec_q <= vec_d;
      net_gnt_q <= net_gnt_d;
      lb_req_q <= lb_req_d;
      lb_sel_q <= lb_sel_d;
      lb_wr_q <= lb_wr_d;
      lb_addr_q <= lb_addr_d;
      lb_wdata_q <= lb_wdata_d;
      rrst_q <= rrst_d;
    end
  end

  assign ext_asack_o = ext_asack_q;
  assign ext_ack_o = ext_ack_q;
  assign ext_rdata_o = ext_rdata_q;
  assign cpu_ack_o = cpu_ack_q;
  assign cpu_rdata_o = cpu_rdata_q;
  assign bus_error_strobe_o = bus_error_strobe_q;
  assign cpu_irq_level_o = lvl_q;
  assign cpu_irq_vector_o = vec_q;
  assign net_gnt_o = net_gnt_q;
  assign lb_req_o = lb_req_q;
  assign lb_sel_o = lb_sel_q;
  assign lb_wr_o = lb_wr_q;
  assign lb_addr_o = lb_addr_q;
  assign lb_wdata_o = lb_wdata_q;
  assign slave_bus_irq_o = csw_q[CSW_BUSIRQ_BIT];
  assign direct_buffer_mode_o = csw_q[CSW_DBM_BIT];
  assign master_mode_o = master_q;
  assign remote_reset_o = rrst_q;

  property p_mask_reset;
    @(posedge clk_i) $fell(rst_i) |-> imsk_q == 8'h00;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not clear after reset");

  property p_bus_error_strobe_timeout;
    @(posedge clk_i) disable iff (rst_i)
      bus_error_strobe_q |-> $past(tmo_q) == 12'(TMO_CYC - 1) && !$past(csw_q[5]);
  endproperty
  a_bus_error_strobe_timeout: assert property (p_bus_error_strobe_timeout)
    else $error("bus error without full timeout");

  property p_bus_error_strobe_suppress;
    @(posedge clk_i) disable iff (rst_i)
      csw_q[5] && $stable(csw_q) |=> !bus_error_strobe_q;
  endproperty
  a_bus_error_strobe_suppress: assert property (p_bus_error_strobe_suppress)
    else $error("bus error while suppressed");

  property p_ext_over_net;
    @(posedge clk_i) disable iff (rst_i)
      state_q == ST_IDLE && ext_hit && !ext_ack_q && net_req_i
      |=> state_q == ST_EXT && !net_gnt_q;
  endproperty
  a_ext_over_net: assert property (p_ext_over_net)
    else $error("network beat the external bus");

  property p_master_no_ext;
    @(posedge clk_i) disable iff (rst_i)
      master_q |-> state_q != ST_EXT;
  endproperty
  a_master_no_ext: assert property (p_master_no_ext)
    else $error("external access in master mode");

  property p_cpu_not_preempted;
    @(posedge clk_i) disable iff (rst_i)
      state_q == ST_CPU |-> ##1 (state_q == ST_CPU || state_q == ST_REL);
  endproperty
  a_cpu_not_preempted: assert property (p_cpu_not_preempted)
    else $error("processor access interrupted");

  property p_remote_reset;
    @(posedge clk_i) disable iff (rst_i)
      rrst_q |-> $past(state_q) == ST_EXT && csw_q == CSW_REMOTE_RST;
  endproperty
  a_remote_reset: assert property (p_remote_reset)
    else $error("remote reset without external write of 2");

  property p_rtc_nibble;
    @(posedge clk_i) disable iff (rst_i)
      cpu_ack_q && $past(acc_sel) == SEL_RTC |-> cpu_rdata_q[31:4] == '0;
  endproperty
  a_rtc_nibble: assert property (p_rtc_nibble)
    else $error("upper clock bits not zero");

  property p_slave_xlate;
    @(posedge clk_i) disable iff (rst_i)
      state_q == ST_EXT |-> acc_addr[31:21] == 11'h020;
  endproperty
  a_slave_xlate: assert property (p_slave_xlate)
    else $error("slave address not mapped to internal window");

  property p_edge_latch;
    @(posedge clk_i) disable iff (rst_i)
      $rose(irq_prev_q[6]) |-> edge_q[6];
  endproperty
  a_edge_latch: assert property (p_edge_latch)
    else $error("timer edge not latched");
endmodule // clbg_top

// File: rtl/clbg_pkg.sv
// Constants and types for the crate local bus glue
package clbg_pkg;
  localparam logic [31:0] CSW_ADDR = 32'h041BE6C0;
  localparam logic [31:0] SRB_ADDR = 32'h041C0000;
  localparam logic [20:0] SLV_RAM_OFF = 21'h000000;
  localparam logic [20:0] SLV_CRATE_OFF = 21'h180000;
  localparam logic [20:0] SLV_CSW_OFF = 21'h1BE6C0;
  localparam logic [20:0] SLV_SRB_OFF = 21'h1C0000;
  localparam logic [31:0] SLV_BASE = 32'h04000000;
  localparam logic [31:0] SER_BASE = 32'h0C000000;
  localparam logic [31:0] NET_BASE = 32'h0C010000;
  localparam logic [31:0] RTC_BASE = 32'h0C020000;
  localparam logic [31:0] DBUF_BASE = 32'h0C035000;
  localparam logic [31:0] DISK_BASE = 32'h0C036000;
  localparam logic [31:0] DCNT_ADDR = 32'h0C037000;
  localparam logic [31:0] ISRC_ADDR = 32'h0C040002;
  localparam logic [31:0] IMSK_ADDR = 32'h0C040003;
  localparam logic [31:0] PAGE_MASK = 32'hFFFF0000;
  localparam logic [31:0] DPAGE_MASK = 32'hFFFFF000;
  localparam int SLV_CRATE_LSB = 21;
  localparam int CSW_BUSIRQ_BIT = 1;
  localparam int CSW_NOBERR_BIT = 5;
  localparam int CSW_DBM_BIT = 7;
  localparam logic [31:0] CSW_RESET = 32'h00000000;
  localparam logic [31:0] CSW_REMOTE_RST = 32'h00000002;
  localparam logic [7:0] IMSK_RESET = 8'h00;
  localparam logic [7:0] IRQ_EDGE_MASK = 8'hC0;
  localparam int LVL_BUS = 1;
  localparam int LVL_SER = 2;
  localparam int LVL_NET = 3;
  localparam int LVL_DISK = 5;
  localparam int LVL_TMR = 6;
  localparam logic [7:0] VEC_BASE = 8'h68;
  localparam logic [15:0] DCNT_STEP = 16'h0002;
  localparam int TMO_NS = 25000;
  localparam int CLK_NS = 10;
  localparam int TMO_CYC = TMO_NS / CLK_NS;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  typedef enum logic [3:0] {SEL_NONE, SEL_RAM, SEL_CRATE, SEL_CSW, SEL_SRB,
    SEL_SER, SEL_NET, SEL_RTC, SEL_DBUF, SEL_DISK, SEL_DCNT, SEL_ISRC,
    SEL_IMSK} clbg_sel_t;
endpackage

// File: rtl/clbg_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module clbg_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule // clbg_sync

// File: verif/clbg_peer.sv
// Local bus peripheral responder with adjustable answer delay
`timescale 1ns/100ps
module clbg_peer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] dly_i,
  input wire logic req_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  localparam logic [31:0] DATA = 32'hA5C396F3;
  logic [3:0] cnt_q;
  logic done_q;
  // Read data flips every cycle outside the ack so stale data shows
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      ack_o <= 1'h0;
      rdata_o <= 32'h0;
      cnt_q <= 4'h0;
      done_q <= 1'h0;
    end
    else
    begin
      ack_o <= 1'h0;
      rdata_o <= ~rdata_o;
      if (!req_i)
      begin
        cnt_q <= 4'h0;
        done_q <= 1'h0;
      end
      else if (!done_q && cnt_q == dly_i)
      begin
        ack_o <= 1'h1;
        rdata_o <= DATA;
        done_q <= 1'h1;
      end
      else if (!done_q)
        cnt_q <= cnt_q + 4'h1;
    end
endmodule // clbg_peer

// File: verif/tb.sv
// Self-checking testbench for the crate local bus glue
`timescale 1ns/100ps
module tb;
  import clbg_pkg::*;
  typedef struct {
    logic [31:0] a;
    logic [1:0] sz;
    clbg_sel_t sel;
    logic [31:0] mask;
    logic [31:0] exp;
    logic [3:0] dly;
  } clbg_row_t;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [3:0] crate_num_i = 4'h1;
  logic [3:0] dly = 4'h0;
  logic ext_as_i, ext_ds_i, ext_wr_i, cpu_req_i, cpu_wr_i, net_req_i;
  logic ext_asack_o, ext_ack_o, cpu_ack_o, bus_error_strobe_o, net_gnt_o;
  logic lb_req_o, lb_wr_o, lb_ack_i, slave_bus_irq_o, remote_reset_o;
  logic direct_buffer_mode_o, master_mode_o, bev, gotack, wr_seen;
  logic rr_seen = 1'h0;
  logic [31:0] ext_addr_i, ext_wdata_i, ext_rdata_o, cpu_addr_i;
  logic [31:0] cpu_wdata_i, cpu_rdata_o, lb_addr_o, lb_wdata_o;
  logic [31:0] lb_rdata_i, rdv, addr_seen, wd_seen;
  logic [7:0] cpu_irq_vector_o, irq_src_i, bus_irq_vector_i;
  logic [23:0] service_req_i;
  logic [2:0] cpu_irq_level_o;
  logic [1:0] cpu_size_i;
  clbg_sel_t lb_sel_o, sel_seen;
  int miscompares = 0;
  int tests_run = 0;
  int ncyc;
  time t_cpu, t_ext;
  int lv[3] = '{2, 3, 5};
  clbg_row_t rows[5] = '{
    '{SER_BASE + 1, SZ_BYTE, SEL_SER, 32'hFF, 32'hF3, 4'h0},
    '{NET_BASE + 4, SZ_WORD, SEL_NET, 32'hFFFF, 32'h96F3, 4'h7},
    '{RTC_BASE, SZ_BYTE, SEL_RTC, 32'hFF, 32'h03, 4'h2},
    '{DISK_BASE + 1, SZ_BYTE, SEL_DISK, 32'hFF, 32'hF3, 4'h9},
    '{DBUF_BASE, SZ_WORD, SEL_DBUF, 32'hFFFF, 32'h96F3, 4'h1}};

  clbg_top dut_u (.*);
  clbg_peer peer_u (.clk_i(clk_i), .rst_i(rst_i), .dly_i(dly),
    .req_i(lb_req_o), .ack_o(lb_ack_i), .rdata_o(lb_rdata_i));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (lb_req_o === 1'h1)
    begin
      sel_seen <= lb_sel_o;
      addr_seen <= lb_addr_o;
      wr_seen <= lb_wr_o;
      wd_seen <= lb_wdata_o;
    end
    if (remote_reset_o === 1'h1)
      rr_seen <= 1'h1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic do_reset();
    rst_i = 1'h1;
    tick(8);
    rst_i = 1'h0;
    tick(4);
  endtask

  // Request held until ack, bus error or lim cycles, dropped in that cycle
  task automatic cpu(input logic wr, input logic [1:0] sz,
    input logic [31:0] a, input logic [31:0] d, input int lim);
    tick(1);
    cpu_wr_i = wr;
    cpu_size_i = sz;
    cpu_addr_i = a;
    cpu_wdata_i = d;
    cpu_req_i = 1'h1;
    ncyc = 0;
    do
    begin
      tick(1);
      ncyc++;
      bev = (bus_error_strobe_o === 1'h1);
    end
    while (cpu_ack_o !== 1'h1 && !bev && ncyc < lim);
    rdv = cpu_rdata_o;
    t_cpu = $time;
    cpu_req_i = 1'h0;
  endtask

  task automatic ext(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    int n;
    tick(1);
    ext_wr_i = wr;
    ext_addr_i = a;
    ext_wdata_i = d;
    ext_as_i = 1'h1;
    ext_ds_i = 1'h1;
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (ext_ack_o !== 1'h1 && n < 40);
    gotack = (ext_ack_o === 1'h1) && (ext_asack_o === 1'h1);
    rdv = ext_rdata_o;
    t_ext = $time;
    ext_as_i = 1'h0;
    ext_ds_i = 1'h0;
    n = 0;
    while (ext_asack_o !== 1'h0 && n < 20)
    begin
      tick(1);
      n++;
    end
  endtask

  initial
  begin
    #300000;
    miscompares++;
    close_out();
  end

  initial
  begin
    {ext_as_i, ext_ds_i, ext_wr_i, cpu_req_i, cpu_wr_i, net_req_i} = '0;
    {ext_addr_i, ext_wdata_i, cpu_addr_i, cpu_wdata_i} = '0;
    {cpu_size_i, irq_src_i, bus_irq_vector_i, service_req_i} = '0;
    do_reset();
    cpu(1'h1, SZ_WORD, DCNT_ADDR, 32'h0010, 20);
    foreach (rows[i])
    begin
      dly = rows[i].dly;
      cpu(1'h0, rows[i].sz, rows[i].a, 32'h0, 40);
      chk(rdv & rows[i].mask, rows[i].exp);
      chk(32'(sel_seen), 32'(rows[i].sel));
    end
    chk(addr_seen, 32'h0C030010);
    cpu(1'h0, SZ_WORD, DBUF_BASE, 32'h0, 40);
    chk(addr_seen, 32'h0C030012);
    cpu(1'h1, SZ_BYTE, SER_BASE, 32'h5A, 40);
    chk({31'h0, wr_seen}, 32'h1);
    chk(wd_seen, 32'h5A);
    // Interrupt controller registers and routing
    cpu(1'h0, SZ_BYTE, IMSK_ADDR, 32'h0, 20);
    chk({24'h0, rdv[7:0]}, 32'h00);
    cpu(1'h1, SZ_BYTE, IMSK_ADDR, 32'hFF, 20);
    cpu(1'h1, SZ_BYTE, ISRC_ADDR, 32'hFF, 20);
    cpu(1'h0, SZ_BYTE, IMSK_ADDR, 32'h0, 20);
    chk({24'h0, rdv[7:0]}, 32'hFF);
    cpu(1'h0, SZ_BYTE, ISRC_ADDR, 32'h0, 20);
    chk({24'h0, rdv[7:0]}, 32'h00);
    foreach (lv[i])
    begin
      irq_src_i = 8'h1 << lv[i];
      tick(6);
      chk({29'h0, cpu_irq_level_o}, lv[i]);
      chk({24'h0, cpu_irq_vector_o}, VEC_BASE + lv[i]);
      irq_src_i = 8'h0;
      tick(6);
      chk({29'h0, cpu_irq_level_o}, 32'h0);
    end
    bus_irq_vector_i = 8'h42;
    irq_src_i = 8'h02;
    tick(6);
    chk({29'h0, cpu_irq_level_o}, 32'h1);
    chk({24'h0, cpu_irq_vector_o}, 32'h42);
    irq_src_i = 8'h40;
    tick(1);
    irq_src_i = 8'h0;
    tick(6);
    chk({29'h0, cpu_irq_level_o}, 32'h6);
    cpu(1'h0, SZ_BYTE, ISRC_ADDR, 32'h0, 20);
    chk({24'h0, rdv[7:0]}, 32'h40);
    tick(4);
    chk({29'h0, cpu_irq_level_o}, 32'h0);
    // Refused accesses run into the timeout
    cpu(1'h0, SZ_BYTE, 32'h0E000000, 32'h0, 3000);
    chk({31'h0, bev}, 32'h1);
    chk({31'h0, ncyc >= TMO_CYC && ncyc <= TMO_CYC + 3}, 32'h1);
    cpu(1'h0, SZ_WORD, SER_BASE, 32'h0, 3000);
    chk({31'h0, bev}, 32'h1);
    cpu(1'h0, SZ_BYTE, DBUF_BASE, 32'h0, 3000);
    chk({31'h0, bev}, 32'h1);
    cpu(1'h1, 2'h2, CSW_ADDR, 32'hA0, 20);
    tick(2);
    chk({31'h0, direct_buffer_mode_o}, 32'h1);
    cpu(1'h0, SZ_BYTE, 32'h0E000000, 32'h0, TMO_CYC + 20);
    chk({31'h0, bev}, 32'h0);
    // Held request is taken again; let that retry run out
    tick(TMO_CYC);
    cpu(1'h1, 2'h2, CSW_ADDR, 32'h0, 20);
    // External slave side, crate 1, junk in ignored upper bits
    ext(1'h1, {7'h7F, 4'h1, SLV_CSW_OFF}, 32'h80);
    chk({31'h0, direct_buffer_mode_o}, 32'h1);
    ext(1'h0, {7'h55, 4'h1, SLV_CSW_OFF}, 32'h0);
    chk(rdv, 32'h80);
    service_req_i = 24'hC3A5E1;
    ext(1'h0, {7'h00, 4'h1, SLV_SRB_OFF}, 32'h0);
    chk(rdv, 32'h00C3A5E1);
    dly = 4'h3;
    ext(1'h0, {7'h00, 4'h1, SLV_RAM_OFF + 21'h10}, 32'h0);
    chk(addr_seen, SLV_BASE + 32'h10);
    chk(rdv, 32'hA5C396F3);
    ext(1'h0, {7'h00, 4'h1, SLV_CRATE_OFF + 21'h800}, 32'h0);
    chk(addr_seen, 32'h04180800);
    chk(32'(sel_seen), 32'(SEL_CRATE));
    ext(1'h0, {7'h00, 4'h2, SLV_CSW_OFF}, 32'h0);
    chk({31'h0, gotack}, 32'h0);
    dly = 4'hC;
    fork
      cpu(1'h0, SZ_BYTE, NET_BASE, 32'h0, 40);
      ext(1'h0, {7'h00, 4'h1, SLV_RAM_OFF}, 32'h0);
    join
    chk({31'h0, t_cpu < t_ext}, 32'h1);
    net_req_i = 1'h1;
    tick(2);
    chk({31'h0, net_gnt_o}, 32'h1);
    net_req_i = 1'h0;
    tick(2);
    chk({31'h0, net_gnt_o}, 32'h0);
    // Both ask in the same idle cycle: the external access must win
    net_req_i = 1'h1;
    fork
      ext(1'h0, {7'h00, 4'h1, SLV_RAM_OFF}, 32'h0);
      begin
        tick(6);
        net_req_i = 1'h0;
        tick(1);
        net_req_i = 1'h1;
        tick(2);
        chk({31'h0, net_gnt_o}, 32'h0);
      end
    join
    chk({31'h0, gotack}, 32'h1);
    chk({31'h0, net_gnt_o}, 32'h1);
    net_req_i = 1'h0;
    tick(2);
    ext(1'h1, {7'h00, 4'h1, SLV_CSW_OFF}, CSW_REMOTE_RST);
    tick(2);
    chk({31'h0, rr_seen}, 32'h1);
    chk({31'h0, slave_bus_irq_o}, 32'h1);
    // Crate zero selects master mode; slave accesses are ignored
    crate_num_i = 4'h0;
    do_reset();
    chk({31'h0, master_mode_o}, 32'h1);
    ext(1'h0, {7'h00, 4'h0, SLV_CSW_OFF}, 32'h0);
    chk({31'h0, gotack}, 32'h0);
    net_req_i = 1'h1;
    tick(2);
    chk({31'h0, net_gnt_o}, 32'h1);
    net_req_i = 1'h0;
    close_out();
  end
endmodule // tb
